// *** pwmd_core.sv ***
// Waveform generation and dithering core of a control timer/counter
// How it works
// - 3-bit waveform_select picks operation; code 3 reserved; not synchronised.
// - Normal frequency: top is period, toggle on match, overflow at top/zero.
// - Match frequency: top is compare channel zero, otherwise like normal frequency.
// - Single-slope PWM: top is period, set on match, clear on update.
// - Dual-slope critical/bottom: update and overflow only at zero, output ~dir on match.
// - Dual-slope both: update and overflow at top and zero, output ~dir on match.
// - Dual-slope top: update at zero only, overflow at top only.
// - Dither adds dither-count extra pulse cycles over every 64 frames.
// - Dither count sits in low 0, 4, 5 or 6 bits by resolution.
// - Resolution codes 0..3 give integer part bits 23:0, 23:4, 23:5, 23:6.
module pwmd_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Configuration from software registers (same clock domain)
  input wire pwmd_pkg::pwmd_cfg_t i_cfg,
  // Counter state and waveform
  output pwmd_pkg::pwmd_stat_t o_stat
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Integer part of a period or compare value
  function automatic logic [23:0] pwmd_int_part(input logic [23:0] v, input pwmd_pkg::pwmd_res_t r);
    logic [23:0] res;
    res = v;
    case (r)
      pwmd_pkg::four_bit_dither: res = v >> pwmd_pkg::SHIFT_FOUR;
      pwmd_pkg::five_bit_dither: res = v >> pwmd_pkg::SHIFT_FIVE;
      pwmd_pkg::six_bit_dither: res = v >> pwmd_pkg::SHIFT_SIX;
      default: res = v >> pwmd_pkg::SHIFT_NONE;
    endcase
    return res;
  endfunction : pwmd_int_part

  // Dither count held in the low bits of a value
  function automatic logic [5:0] pwmd_dith_part(input logic [23:0] v, input pwmd_pkg::pwmd_res_t r);
    logic [5:0] res;
    res = 6'h00;
    case (r)
      pwmd_pkg::four_bit_dither: res = v[5:0] & pwmd_pkg::MASK_FOUR;
      pwmd_pkg::five_bit_dither: res = v[5:0] & pwmd_pkg::MASK_FIVE;
      pwmd_pkg::six_bit_dither: res = v[5:0] & pwmd_pkg::MASK_SIX;
      default: res = 6'h00;
    endcase
    return res;
  endfunction : pwmd_dith_part

  // Accumulator step: carry out means one extra cycle next frame
  function automatic logic [6:0] pwmd_acc_step(input logic [5:0] acc, input logic [5:0] d);
    return {1'b0, acc} + {1'b0, d};
  endfunction : pwmd_acc_step

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [23:0] count_q, count_d;
  logic dir_q, dir_d;
  logic wave_q, wave_d;
  logic ovf_q, ovf_d;
  logic upd_q, upd_d;
  logic [23:0] prd_buf_q, prd_buf_d;
  logic [23:0] cmp0_buf_q, cmp0_buf_d;
  logic [5:0] acc_prd_q, acc_prd_d;
  logic [5:0] acc_cmp_q, acc_cmp_d;
  logic xper_q, xper_d;
  logic xcmp_q, xcmp_d;

  // Decoded mode and frame events
  pwmd_pkg::pwmd_wave_t mode;
  logic dual, freq, run;
  logic [23:0] prd_int, cmp0_int, top, cmp;
  logic at_top, at_zero, match;
  logic top_ev, zero_ev, upd_ev, ovf_ev, frame_end;
  logic [6:0] prd_sum, cmp_sum;

  // ----------------------------------------------------------------
  // Top, compare and events
  // ----------------------------------------------------------------
  // The selector is used raw: it comes straight from a register on this clock
  always_comb
  begin
    mode = i_cfg.waveform_select;
    dual = mode[2];
    freq = (mode == pwmd_pkg::normal_frequency_mode) || (mode == pwmd_pkg::match_frequency_mode);
    run = i_cfg.enable && (mode != pwmd_pkg::reserved_mode);
    prd_int = pwmd_int_part(prd_buf_q, i_cfg.dither_resolution);
    cmp0_int = pwmd_int_part(cmp0_buf_q, i_cfg.dither_resolution);
    // Match frequency runs off channel zero instead of the period
    if (mode == pwmd_pkg::match_frequency_mode)
    begin
      top = cmp0_int + {23'h000000, xcmp_q};
    end
    else
    begin
      top = prd_int + {23'h000000, xper_q};
    end
    // PWM pulse grows by moving the match point one cycle earlier
    if (!freq && xcmp_q && (cmp0_int != 24'h000000))
    begin
      cmp = cmp0_int - 24'h000001;
    end
    else
    begin
      cmp = cmp0_int;
    end
    at_top = (count_q == top);
    at_zero = (count_q == 24'h000000);
    match = run && (count_q == cmp);
    top_ev = run && (dual ? (!dir_q && at_top) : (!i_cfg.count_down && at_top));
    zero_ev = run && (dual ? (dir_q && at_zero) : (i_cfg.count_down && at_zero));
    // Update points per mode
    case (mode)
      pwmd_pkg::dual_slope_both_mode: upd_ev = top_ev || zero_ev;
      pwmd_pkg::dual_slope_critical_mode,
      pwmd_pkg::dual_slope_bottom_mode,
      pwmd_pkg::dual_slope_top_mode: upd_ev = zero_ev;
      default: upd_ev = top_ev || zero_ev;
    endcase
    // Overflow points per mode
    case (mode)
      pwmd_pkg::dual_slope_critical_mode,
      pwmd_pkg::dual_slope_bottom_mode: ovf_ev = zero_ev;
      pwmd_pkg::dual_slope_top_mode: ovf_ev = top_ev;
      default: ovf_ev = top_ev || zero_ev;
    endcase
    // One dither frame per full period
    frame_end = dual ? zero_ev : (top_ev || zero_ev);
    prd_sum = pwmd_acc_step(acc_prd_q, pwmd_dith_part(prd_buf_q, i_cfg.dither_resolution));
    cmp_sum = pwmd_acc_step(acc_cmp_q, pwmd_dith_part(cmp0_buf_q, i_cfg.dither_resolution));
  end

  // ----------------------------------------------------------------
  // Counter, buffers and dither accumulators
  // ----------------------------------------------------------------
  // While running, buffered period and compare only change at update points, so a frame is never torn
  always_comb
  begin
    count_d = count_q;
    dir_d = dir_q;
    prd_buf_d = prd_buf_q;
    cmp0_buf_d = cmp0_buf_q;
    acc_prd_d = acc_prd_q;
    acc_cmp_d = acc_cmp_q;
    xper_d = xper_q;
    xcmp_d = xcmp_q;
    if (!i_cfg.enable)
    begin
      // Stopped: follow the live values so the first frame uses them
      prd_buf_d = i_cfg.period_value;
      cmp0_buf_d = i_cfg.compare_channel_zero;
    end
    else if (run)
    begin
      if (dual)
      begin
        if (top_ev)
        begin
          dir_d = 1'b1;
          count_d = (count_q == 24'h000000) ? count_q : count_q - 24'h000001;
        end
        else if (zero_ev)
        begin
          dir_d = 1'b0;
          count_d = at_top ? count_q : count_q + 24'h000001; // A zero top must not run away upwards
        end
        else
        begin
          count_d = dir_q ? count_q - 24'h000001 : count_q + 24'h000001;
        end
      end
      else
      begin
        dir_d = i_cfg.count_down;
        if (top_ev)
        begin
          count_d = pwmd_pkg::RST_COUNT;
        end
        else if (zero_ev)
        begin
          count_d = top;
        end
        else
        begin
          count_d = i_cfg.count_down ? count_q - 24'h000001 : count_q + 24'h000001;
        end
      end
      if (upd_ev)
      begin
        prd_buf_d = i_cfg.period_value;
        cmp0_buf_d = i_cfg.compare_channel_zero;
      end
      if (frame_end)
      begin
        acc_prd_d = prd_sum[5:0];
        acc_cmp_d = cmp_sum[5:0];
        xper_d = prd_sum[6];
        xcmp_d = cmp_sum[6];
      end
    end
  end

  // ----------------------------------------------------------------
  // Waveform output and event pulses
  // ----------------------------------------------------------------
  // In single-slope PWM the clear on update wins when it meets a match
  always_comb
  begin
    wave_d = wave_q;
    ovf_d = ovf_ev;
    upd_d = upd_ev;
    case (mode)
      pwmd_pkg::normal_frequency_mode,
      pwmd_pkg::match_frequency_mode:
      begin
        if (match)
        begin
          wave_d = ~wave_q;
        end
      end
      pwmd_pkg::single_slope_pwm_mode:
      begin
        if (upd_ev)
        begin
          wave_d = 1'b0;
        end
        else if (match)
        begin
          wave_d = 1'b1;
        end
      end
      pwmd_pkg::reserved_mode: wave_d = wave_q;
      default:
      begin
        if (match)
        begin
          wave_d = ~dir_q;
        end
      end
    endcase
  end

  // Registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      count_q <= pwmd_pkg::RST_COUNT;
      dir_q <= 1'b0;
      wave_q <= 1'b0;
      ovf_q <= 1'b0;
      upd_q <= 1'b0;
      prd_buf_q <= pwmd_pkg::RST_COUNT;
      cmp0_buf_q <= pwmd_pkg::RST_COUNT;
      acc_prd_q <= pwmd_pkg::RST_ACC;
      acc_cmp_q <= pwmd_pkg::RST_ACC;
      xper_q <= 1'b0;
      xcmp_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      dir_q <= dir_d;
      wave_q <= wave_d;
      ovf_q <= ovf_d;
      upd_q <= upd_d;
      prd_buf_q <= prd_buf_d;
      cmp0_buf_q <= cmp0_buf_d;
      acc_prd_q <= acc_prd_d;
      acc_cmp_q <= acc_cmp_d;
      xper_q <= xper_d;
      xcmp_q <= xcmp_d;
    end
  end

  // Status out, all from flip-flops
  assign o_stat = '{count: count_q, dir_down: dir_q, wave: wave_q, overflow_flag: ovf_q, update: upd_q};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_reserved_code_idle: assert property (
    (mode == pwmd_pkg::reserved_mode) |=> $stable(count_q) && !ovf_q && $stable(wave_q))
    else $error("reserved waveform code moved the counter");
  a_freq_wrap_top: assert property (
    (mode == pwmd_pkg::normal_frequency_mode) && i_cfg.enable && !i_cfg.count_down && at_top
    |=> ovf_q && (count_q == 24'h000000))
    else $error("normal frequency top did not wrap with overflow");
  a_match_freq_top: assert property (
    (mode == pwmd_pkg::match_frequency_mode) && i_cfg.enable && !i_cfg.count_down
    && (count_q == cmp0_int) && !xcmp_q |=> ovf_q && (count_q == 24'h000000))
    else $error("match frequency did not wrap at channel zero");
  a_pwm_clear_update: assert property (
    (mode == pwmd_pkg::single_slope_pwm_mode) && upd_ev |=> !wave_q && upd_q)
    else $error("single-slope output not cleared on update");
  a_bottom_zero_only: assert property (
    ((mode == pwmd_pkg::dual_slope_bottom_mode) || (mode == pwmd_pkg::dual_slope_critical_mode))
    && top_ev |=> !ovf_q && !upd_q && dir_q)
    else $error("dual-slope bottom flagged at top");
  a_both_two_points: assert property (
    (mode == pwmd_pkg::dual_slope_both_mode) && (top_ev || zero_ev) |=> ovf_q && upd_q)
    else $error("dual-slope both missed an event");
  a_top_no_zero: assert property (
    (mode == pwmd_pkg::dual_slope_top_mode) && zero_ev |=> !ovf_q ##0 upd_q)
    else $error("dual-slope top flagged overflow at zero");
  a_ds_match_dir: assert property (
    dual && run && match |=> (wave_q == !$past(dir_q)))
    else $error("dual-slope output not inverse of direction");
  a_dither_carry: assert property (
    run && frame_end && (prd_sum >= pwmd_pkg::DITH_FRAMES) |=> xper_q)
    else $error("dither carry lost");
  a_none_no_extra: assert property (
    (i_cfg.dither_resolution == pwmd_pkg::no_dither) && run && frame_end && !xper_q |=> !xper_q && !xcmp_q)
    else $error("extra cycle without dither");
  a_acc_advance: assert property (
    run && frame_end |=> ({1'b0, acc_prd_q} == ($past(prd_sum) & 7'h3f)))
    else $error("dither accumulator did not advance");

  c_freq_overflow: cover property ((mode == pwmd_pkg::normal_frequency_mode) && ovf_ev);
  c_pwm_pulse: cover property ((mode == pwmd_pkg::single_slope_pwm_mode) && match ##[1:300] upd_ev);
  c_dual_turn: cover property (dual && top_ev ##[1:300] zero_ev);
  c_dither_extra: cover property (run && frame_end && prd_sum[6]);

endmodule : pwmd_core

// *** pwmd_core_tb.sv ***
// Self-checking testbench for the dithered waveform generator core
module pwmd_core_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Clock, reset and stimulus
  // ----------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  pwmd_pkg::pwmd_cfg_t cfg = '0;
  pwmd_pkg::pwmd_stat_t st;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  // Free-running 100 MHz clock
  always #5 i_clk = ~i_clk;

  pwmd_core u_pwmd_core (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_cfg(cfg),
    .o_stat(st)
  );

  // Hang guard: far above the few thousand cycles the tests need
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Reset, load config while stopped, then run; reset keeps count below any new top
  task automatic setcfg(input logic [2:0] m, input logic [1:0] r, input logic [23:0] p,
                        input logic [23:0] c, input logic dn);
    pwmd_pkg::pwmd_cfg_t t;
    t.enable = 1'b0;
    t.count_down = dn;
    t.waveform_select = pwmd_pkg::pwmd_wave_t'(m);
    t.dither_resolution = pwmd_pkg::pwmd_res_t'(r);
    t.period_value = p;
    t.compare_channel_zero = c;
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    cfg <= t;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    cfg.enable <= 1'b1;
  endtask : setcfg

  // Waits at the settled half of the clock for an event pulse (0 overflow, 1 update)
  task automatic wait_pulse(input bit sel);
    int n;
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
    end
    while ((sel ? st.update : st.overflow_flag) !== 1'b1 && n < 300);
    if (n >= 300)
      check(32'h0, 32'h1);
  endtask : wait_pulse

  // Cycles between two consecutive event pulses
  task automatic gap(input bit sel, output int n);
    wait_pulse(sel);
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
    end
    while ((sel ? st.update : st.overflow_flag) !== 1'b1 && n < 300);
  endtask : gap

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_freq();
    int n;
    logic w;
    setcfg(3'h0, 2'h0, 24'h3, 24'h1, 1'b0);
    gap(1'b0, n);
    check(n, 4);
    w = st.wave;
    check(st.count, 24'h0);
    gap(1'b1, n);
    check(n, 4);
    wait_pulse(1'b0);
    check(st.wave, !w);
    setcfg(3'h0, 2'h0, 24'h3, 24'h1, 1'b1);
    gap(1'b0, n);
    check(n, 4);
    check(st.count, 24'h3);
    setcfg(3'h1, 2'h0, 24'h3, 24'h9, 1'b0);
    gap(1'b1, n);
    check(n, 10);
    gap(1'b0, n);
    check(n, 10);
    $display("freq test done");
  endtask : t_freq

  task automatic t_pwm();
    int hi;
    setcfg(3'h2, 2'h0, 24'h7, 24'h3, 1'b0);
    wait_pulse(1'b1);
    check(st.wave, 1'b0);
    hi = 0;
    repeat (8)
    begin
      hi += int'(st.wave === 1'b1);
      @(negedge i_clk);
    end
    check(hi, 4);
    $display("pwm test done");
  endtask : t_pwm

  task automatic t_dual();
    int n;
    for (int m = 4; m < 8; m++)
    begin
      setcfg(m[2:0], 2'h0, 24'h6, 24'h2, 1'b0);
      gap(1'b1, n);
      check(n, (m == 6) ? 6 : 12);
      gap(1'b0, n);
      check(n, (m == 6) ? 6 : 12);
      if (m != 6)
      begin
        check(st.dir_down, m == 7);
        check(st.count, (m == 7) ? 24'h5 : 24'h1);
        check(st.wave, m == 7);
      end
    end
    $display("dual test done");
  endtask : t_dual

  // Frame total over 64 frames for every resolution, dither count at its maximum
  task automatic t_dither();
    int n;
    int k;
    logic [5:0] d;
    for (int r = 0; r < 4; r++)
    begin
      d = (r == 0) ? 6'h00 : (r == 1) ? pwmd_pkg::MASK_FOUR :
          (r == 2) ? pwmd_pkg::MASK_FIVE : pwmd_pkg::MASK_SIX;
      setcfg(3'h2, r[1:0], (24'h5 << ((r == 0) ? 0 : r + 3)) | 24'(d), 24'h1, 1'b0);
      repeat (3) wait_pulse(1'b1);
      n = 0;
      k = 0;
      while (k < 64)
      begin
        @(negedge i_clk);
        n++;
        k += int'(st.update === 1'b1);
      end
      check(n, 64 * 6 + d);
    end
    $display("dither test done");
  endtask : t_dither

  // Pulse width gains the compare dither count over 64 frames
  task automatic t_width();
    int hi;
    setcfg(3'h2, 2'h1, 24'h70, 24'h35, 1'b0);
    repeat (3) wait_pulse(1'b1);
    hi = 0;
    repeat (64 * 8)
    begin
      @(negedge i_clk);
      hi += int'(st.wave === 1'b1);
    end
    check(hi, 64 * 4 + 5);
    $display("width test done");
  endtask : t_width

  // Reserved code freezes a running counter where it stands, with no events
  task automatic t_frozen();
    logic [23:0] c;
    logic w;
    int ev;
    setcfg(3'h2, 2'h0, 24'h4, 24'h1, 1'b0);
    repeat (3) @(posedge i_clk);
    cfg.waveform_select <= pwmd_pkg::reserved_mode;
    repeat (2) @(negedge i_clk);
    c = st.count;
    w = st.wave;
    ev = 0;
    repeat (20)
    begin
      @(negedge i_clk);
      ev += int'(st.update === 1'b1 || st.overflow_flag === 1'b1);
    end
    check(c, 24'h3);
    check(st.count, c);
    check(st.wave, w);
    check(ev, 0);
    $display("frozen test done");
  endtask : t_frozen

  // ----------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_freq();
    t_pwm();
    t_dual();
    t_dither();
    t_width();
    t_frozen();
    print_verdict();
  end

endmodule : pwmd_core_tb

// *** pwmd_pkg.sv ***
// Shared constants and carrier types for the dithered waveform generator
package pwmd_pkg;

  // ----------------------------------------------------------------
  // Widths and dither layout
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 24;
  localparam int unsigned ACC_W = 6;
  localparam logic [6:0] DITH_FRAMES = 7'h40;
  localparam logic [4:0] SHIFT_NONE = 5'h00;
  localparam logic [4:0] SHIFT_FOUR = 5'h04;
  localparam logic [4:0] SHIFT_FIVE = 5'h05;
  localparam logic [4:0] SHIFT_SIX = 5'h06;
  localparam logic [5:0] MASK_FOUR = 6'h0f;
  localparam logic [5:0] MASK_FIVE = 6'h1f;
  localparam logic [5:0] MASK_SIX = 6'h3f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] RST_COUNT = 24'h000000;
  localparam logic [5:0] RST_ACC = 6'h00;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    normal_frequency_mode = 3'h0,
    match_frequency_mode = 3'h1,
    single_slope_pwm_mode = 3'h2,
    reserved_mode = 3'h3,
    dual_slope_critical_mode = 3'h4,
    dual_slope_bottom_mode = 3'h5,
    dual_slope_both_mode = 3'h6,
    dual_slope_top_mode = 3'h7
  } pwmd_wave_t;

  typedef enum logic [1:0] {
    no_dither = 2'h0,
    four_bit_dither = 2'h1,
    five_bit_dither = 2'h2,
    six_bit_dither = 2'h3
  } pwmd_res_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic count_down;
    pwmd_wave_t waveform_select;
    pwmd_res_t dither_resolution;
    logic [23:0] period_value;
    logic [23:0] compare_channel_zero;
  } pwmd_cfg_t;

  typedef struct packed {
    logic [23:0] count;
    logic dir_down;
    logic wave;
    logic overflow_flag;
    logic update;
  } pwmd_stat_t;

endpackage : pwmd_pkg
